//--- design/uart_rx_cfg.svh
// register offsets, field positions and reset values of the receive block
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH
`define A_DATA 12'h000
`define A_STAT 12'h004
`define A_LCTL 12'h01C
`define A_BAUD 12'h024
`define A_IEN 12'h038
`define A_IRAW 12'h03C
`define A_IMSK 12'h040
`define A_ICLR 12'h044
`define F_FE 0
`define F_PE 1
`define F_BE 2
`define F_OE 3
`define E_FE 8
`define E_PE 9
`define E_BE 10
`define L_PEN 1
`define L_EPS 2
`define L_FEN 4
`define L_SPS 7
`define OVS_MID 4'h7
`define OVS_LAST 4'hF
`define RST_BAUD 16'h001A
`define RST_LCTL 8'h00
`define RST_FLAGS 4'h0
`define RST_WORD 32'h0000_0000
`endif

//--- design/uart_rx_pkg.sv
// shared types of the receive block
`default_nettype none
package uart_rx_pkg;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_BITS, RX_PAR, RX_STOP, RX_BRKWAIT
    } rx_state_e;
    typedef logic [7:0] char_t;
endpackage
`default_nettype wire

//--- design/rx_char_if.sv
// one received character with its error flags, deframer to register side
`timescale 1ns/1ps
`default_nettype none
interface rx_char_if;
    logic valid;
    uart_rx_pkg::char_t data;
    logic fe;
    logic pe;
    logic be;
    modport src(output valid, data, fe, pe, be);
    modport dst(input valid, data, fe, pe, be);
endinterface
`default_nettype wire

//--- design/rx_fifo.sv
// receive fifo held in flip-flops; one_deep turns it into a holding register
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(
    parameter int W = 11,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic [W-1:0] wdata,
    input wire logic pop,
    input wire logic one_deep,
    output logic full,
    output logic empty,
    output logic [W-1:0] head
);
    logic [W-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire do_push;
    wire do_pop;

    // depth must be a power of two so the pointers wrap on their own
    assign empty = cnt_reg == '0;
    assign full = one_deep ? !empty : (cnt_reg == (AW+1)'(DEPTH));
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign head = mem_reg[rd_reg];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_reg[wr_reg] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg <= wr_reg + AW'(do_push);
            rd_reg <= rd_reg + AW'(do_pop);
            cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // rx_fifo
`default_nettype wire

//--- design/rx_deframer.sv
// serial receiver: 16x oversampling, parity and stop checks, break capture
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_cfg.svh"
module rx_deframer (
    input wire logic clk,
    input wire logic rst,
    input wire logic rxd,
    input wire logic [15:0] baud_div,
    input wire logic par_en,
    input wire logic par_even,
    input wire logic par_stick,
    rx_char_if.src ch
);
    uart_rx_pkg::rx_state_e state_reg, state_next;
    logic [15:0] div_reg;
    logic [3:0] ovs_reg, ovs_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic par_reg, par_next;
    logic emit;
    wire tick;
    wire mid;
    wire samp;
    wire is_break;

    function automatic logic parity_bit(input logic [7:0] d,
                                        input logic even,
                                        input logic stick);
        parity_bit = stick ? !even : (even ? ^d : ~^d);
    endfunction

    // >= so a lowered divider takes effect at once, not after a wrap
    assign tick = div_reg >= baud_div;
    assign mid = tick && ovs_reg == `OVS_MID;
    assign samp = tick && ovs_reg == `OVS_LAST;
    // whole frame low, stop bit included
    assign is_break = !rxd && shift_reg == '0 && !(par_en && par_reg);

    always_ff @(posedge clk) begin
        if (rst || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    always_comb begin
        state_next = state_reg;
        ovs_next = tick ? ovs_reg + 4'h1 : ovs_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        par_next = par_reg;
        emit = 1'b0;
        case (state_reg)
            uart_rx_pkg::RX_IDLE: begin
                ovs_next = '0;
                if (!rxd) begin
                    state_next = uart_rx_pkg::RX_START;
                    bit_next = '0;
                    par_next = 1'b0;
                end
            end
            uart_rx_pkg::RX_START: begin
                // a start bit that is high at its centre was a glitch
                if (mid) begin
                    state_next = rxd ? uart_rx_pkg::RX_IDLE
                                     : uart_rx_pkg::RX_BITS;
                    ovs_next = '0;
                end
            end
            uart_rx_pkg::RX_BITS: begin
                if (samp) begin
                    shift_next = {rxd, shift_reg[7:1]};
                    bit_next = bit_reg + 3'h1;
                    if (bit_reg == 3'h7) begin
                        state_next = par_en ? uart_rx_pkg::RX_PAR
                                            : uart_rx_pkg::RX_STOP;
                    end
                end
            end
            uart_rx_pkg::RX_PAR: begin
                if (samp) begin
                    par_next = rxd;
                    state_next = uart_rx_pkg::RX_STOP;
                end
            end
            uart_rx_pkg::RX_STOP: begin
                if (samp) begin
                    emit = 1'b1;
                    state_next = is_break ? uart_rx_pkg::RX_BRKWAIT
                                          : uart_rx_pkg::RX_IDLE;
                end
            end
            uart_rx_pkg::RX_BRKWAIT: begin
                if (rxd) begin
                    state_next = uart_rx_pkg::RX_IDLE;
                end
            end
            default: state_next = uart_rx_pkg::RX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= uart_rx_pkg::RX_IDLE;
            ovs_reg <= '0;
            bit_reg <= '0;
            shift_reg <= '0;
            par_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ovs_reg <= ovs_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            par_reg <= par_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ch.valid <= 1'b0;
            ch.data <= '0;
            ch.fe <= 1'b0;
            ch.pe <= 1'b0;
            ch.be <= 1'b0;
        end else begin
            ch.valid <= emit;
            ch.data <= is_break ? '0 : shift_reg;
            ch.fe <= !is_break && !rxd;
            ch.pe <= !is_break && par_en &&
                     par_reg != parity_bit(shift_reg, par_even, par_stick);
            ch.be <= is_break;
        end
    end

    a_break_zero:
    assert property (@(posedge clk) disable iff (rst)
        ch.valid && ch.be |-> ch.data == 8'h00 && !ch.fe && !ch.pe)
        else $error("break character not all zero");

    a_break_wait:
    assert property (@(posedge clk) disable iff (rst)
        state_reg == uart_rx_pkg::RX_BRKWAIT && !rxd
        |=> state_reg == uart_rx_pkg::RX_BRKWAIT && !ch.valid)
        else $error("receiver left break wait while line low");

    a_stop_good:
    assert property (@(posedge clk) disable iff (rst)
        state_reg == uart_rx_pkg::RX_STOP && samp && rxd
        |=> ch.valid && !ch.fe && !ch.be)
        else $error("good stop bit flagged as fault");

    a_stop_bad:
    assert property (@(posedge clk) disable iff (rst)
        state_reg == uart_rx_pkg::RX_STOP && samp && !rxd && !is_break
        |=> ch.valid && ch.fe)
        else $error("low stop bit not flagged");
endmodule // rx_deframer
`default_nettype wire

//--- design/uart_rx_err_top.sv
// uart receive data and error status block with apb register slave
//
// Behaviour
// - Reading the data field returns the received character and writing it hands a character to the transmitter.
// - A character whose stop bit is low raises the stop-bit fault at data bit 8 and status bit 0.
// - A parity bit that disagrees with line control bits 2 and 7 raises the mismatch flag at data bit 9 and status bit 1.
// - A line held low for longer than a whole frame raises the break flag at data bit 10 and status bit 2.
// - A break pushes exactly one all-zero character however long it lasts.
// - After a break no character is taken until the line goes high and a new start bit is seen.
// - A character arriving at a full fifo sets overrun at data bit 11 and status bit 3 and leaves the fifo alone.
// - The data register overrun bit drops as soon as the fifo has a free place.
// - Any write to the error clear register clears all four status flags except those carried by the character at the fifo head.
// - Frame, parity and break flags in the data field belong to the character at the head of the fifo and move with it; the status flags collect them until cleared.
// - Frame, parity, break and overrun errors raise an error interrupt readable in raw and masked status.
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_cfg.svh"
module uart_rx_err_top #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic RXD,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    output logic ERR_IRQ
);
    rx_char_if ch();

    logic [7:0] lctl_reg;
    logic [15:0] baud_reg;
    logic [3:0] stat_reg, stat_next;
    logic [3:0] iraw_reg, iraw_next;
    logic [3:0] ien_reg;
    logic dr_oe_reg, dr_oe_next;
    logic rd_char_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [7:0] tx_data_reg;
    logic tx_valid_reg;
    logic irq_reg;
    logic [31:0] rd_val;
    logic mapped;

    wire fifo_full;
    wire fifo_empty;
    wire [10:0] fifo_head;
    wire acc;
    wire fin;
    wire wr_fin;
    wire rd_cap;
    wire hit_data;
    wire hit_stat;
    wire pop;
    wire ovr;
    wire ecr_wr;
    wire iclr_wr;
    wire [3:0] head_err;
    wire [3:0] new_err;
    wire [7:0] wdata_lo;

    rx_deframer u_deframer (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .rxd(RXD),
        .baud_div(baud_reg),
        .par_en(lctl_reg[`L_PEN]),
        .par_even(lctl_reg[`L_EPS]),
        .par_stick(lctl_reg[`L_SPS]),
        .ch(ch)
    );

    // a full fifo refuses the push, so the stored entries stay valid
    rx_fifo #(.W(11), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .push(ch.valid),
        .wdata({ch.be, ch.pe, ch.fe, ch.data}),
        .pop(pop),
        .one_deep(!lctl_reg[`L_FEN]),
        .full(fifo_full),
        .empty(fifo_empty),
        .head(fifo_head)
    );

    // apb: one wait state, writes and pops happen at the pready edge
    assign acc = PSEL && PENABLE;
    assign fin = acc && pready_reg;
    assign wr_fin = fin && PWRITE;
    assign rd_cap = acc && !pready_reg && !PWRITE;
    assign hit_data = PADDR == `A_DATA;
    assign hit_stat = PADDR == `A_STAT;
    assign ecr_wr = wr_fin && hit_stat;
    assign iclr_wr = wr_fin && PADDR == `A_ICLR;
    assign wdata_lo = PWDATA[7:0];
    // only a read that captured a real character may consume it
    assign pop = fin && !PWRITE && hit_data && rd_char_reg;

    assign ovr = ch.valid && fifo_full;
    assign head_err = fifo_empty ? 4'h0
                    : {1'b0, fifo_head[`E_BE], fifo_head[`E_PE],
                       fifo_head[`E_FE]};
    assign new_err = {ovr, ch.valid && ch.be, ch.valid && ch.pe,
                      ch.valid && ch.fe};

    // set wins over a clear in the same cycle
    assign stat_next = (stat_reg & ~{4{ecr_wr}}) | head_err
                     | {ovr, 3'b000};
    assign iraw_next = (iraw_reg & ~({4{iclr_wr}} & PWDATA[3:0]))
                     | new_err;
    assign dr_oe_next = ovr | (dr_oe_reg & fifo_full);

    always_comb begin
        rd_val = `RST_WORD;
        mapped = 1'b1;
        if (hit_data) begin
            rd_val = {20'h0_0000, dr_oe_reg,
                      fifo_empty ? 11'h000 : fifo_head};
        end else if (hit_stat) begin
            rd_val = {28'h000_0000, stat_reg};
        end else if (PADDR == `A_LCTL) begin
            rd_val = {24'h00_0000, lctl_reg};
        end else if (PADDR == `A_BAUD) begin
            rd_val = {16'h0000, baud_reg};
        end else if (PADDR == `A_IEN) begin
            rd_val = {28'h000_0000, ien_reg};
        end else if (PADDR == `A_IRAW) begin
            rd_val = {28'h000_0000, iraw_reg};
        end else if (PADDR == `A_IMSK) begin
            rd_val = {28'h000_0000, iraw_reg & ien_reg};
        end else if (PADDR == `A_ICLR) begin
            rd_val = `RST_WORD;
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= `RST_WORD;
            rd_char_reg <= 1'b0;
        end else begin
            pready_reg <= acc && !pready_reg;
            pslverr_reg <= acc && !pready_reg && !mapped;
            if (rd_cap) begin
                prdata_reg <= rd_val;
                rd_char_reg <= hit_data && !fifo_empty;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            lctl_reg <= `RST_LCTL;
            baud_reg <= `RST_BAUD;
            ien_reg <= `RST_FLAGS;
        end else if (wr_fin) begin
            if (PADDR == `A_LCTL) begin
                lctl_reg <= wdata_lo;
            end else if (PADDR == `A_BAUD) begin
                baud_reg <= PWDATA[15:0];
            end else if (PADDR == `A_IEN) begin
                ien_reg <= PWDATA[3:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            tx_data_reg <= '0;
            tx_valid_reg <= 1'b0;
        end else begin
            tx_valid_reg <= wr_fin && hit_data;
            if (wr_fin && hit_data) begin
                tx_data_reg <= wdata_lo;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            stat_reg <= `RST_FLAGS;
            iraw_reg <= `RST_FLAGS;
            dr_oe_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            iraw_reg <= iraw_next;
            dr_oe_reg <= dr_oe_next;
            irq_reg <= |(iraw_reg & ien_reg);
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign TX_DATA = tx_data_reg;
    assign TX_VALID = tx_valid_reg;
    assign ERR_IRQ = irq_reg;

    a_tx_handoff:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        wr_fin && hit_data
        |=> TX_VALID && TX_DATA == $past(wdata_lo) ##1 !TX_VALID)
        else $error("written character not handed to transmitter");

    a_read_char:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        rd_cap && hit_data && !fifo_empty
        |=> PRDATA[10:0] == $past(fifo_head) && PREADY)
        else $error("data read does not show head character");

    a_overrun_set:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ovr |=> stat_reg[`F_OE] && dr_oe_reg && iraw_reg[`F_OE])
        else $error("overrun not flagged");

    a_head_kept:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ovr && !pop |=> fifo_full && $stable(fifo_head))
        else $error("full fifo disturbed by overrun");

    a_oe_release:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        dr_oe_reg && !fifo_full && !ovr |=> !dr_oe_reg)
        else $error("overrun bit kept with free fifo space");

    a_clear_all:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ecr_wr && fifo_empty && !ovr |=> stat_reg == 4'h0)
        else $error("error clear left status flags set");

    a_head_flags:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !fifo_empty && fifo_head[`E_PE] |=> stat_reg[`F_PE])
        else $error("head parity flag not reported");

    a_err_irq:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ch.valid && ch.fe && ien_reg[`F_FE] && !wr_fin
        |=> iraw_reg[`F_FE] ##1 ERR_IRQ)
        else $error("frame error did not raise interrupt");

    a_one_deep:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !lctl_reg[`L_FEN] && !fifo_empty |-> fifo_full)
        else $error("holding place not treated as one entry");

    a_par_flag:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ch.valid && ch.pe |=> iraw_reg[`F_PE])
        else $error("parity mismatch not raised");

    a_brk_flag:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ch.valid && ch.be |=> iraw_reg[`F_BE])
        else $error("break not raised");

    a_fe_stat:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !fifo_empty && fifo_head[`E_FE] |=> stat_reg[`F_FE])
        else $error("head stop-bit fault not reported");

    a_push_head:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ch.valid && fifo_empty |=> !fifo_empty &&
        fifo_head == $past({ch.be, ch.pe, ch.fe, ch.data}))
        else $error("character and flags not at fifo head");

    a_pop_char:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        pop |-> !fifo_empty)
        else $error("read popped an empty fifo");

    a_read_empty:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        rd_cap && hit_data && fifo_empty |=> PRDATA[10:0] == 11'h000)
        else $error("empty fifo read shows a character");

    a_ready_pulse:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    a_slverr_ready:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        PSLVERR |-> PREADY)
        else $error("slave error without ready");

    a_oe_cause:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(stat_reg[`F_OE]) |-> $past(ovr))
        else $error("overrun status set without overrun");

    a_dr_oe_cause:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        $rose(dr_oe_reg) |-> $past(ovr))
        else $error("data overrun bit set without overrun");

    a_oe_held:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        stat_reg[`F_OE] && !ecr_wr |=> stat_reg[`F_OE])
        else $error("overrun status dropped without clear");

    a_ecr_any:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        ecr_wr && !ovr |=> !stat_reg[`F_OE])
        else $error("error clear kept overrun status");

    a_raw_held:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        iraw_reg[`F_FE] && !iclr_wr |=> iraw_reg[`F_FE])
        else $error("raw frame interrupt dropped without clear");

    a_raw_clear:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        iclr_wr && new_err == 4'h0
        |=> (iraw_reg & $past(PWDATA[3:0])) == 4'h0)
        else $error("interrupt clear left raw bits set");

    a_tx_quiet:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !(wr_fin && hit_data) |=> !TX_VALID)
        else $error("transmit strobe without data write");

    a_tx_held:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !(wr_fin && hit_data) |=> $stable(TX_DATA))
        else $error("transmit character changed without write");

    a_hold_fill:
    assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !lctl_reg[`L_FEN] && fifo_empty && ch.valid && !wr_fin
        |=> fifo_full)
        else $error("holding place not full after a character");
endmodule // uart_rx_err_top
`default_nettype wire

//--- testbench/serial_tx_model.sv
// serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_tx_model (
    input wire logic clk,
    output logic line
);
    // idle marking level between frames
    initial line = 1'b1;
    // one bit is 16 clocks with the divider written to zero
    task automatic bit_out(input logic v);
        @(posedge clk);
        line <= v;
        repeat (15) @(posedge clk);
    endtask
    task automatic send(input logic [7:0] c, input logic pen,
                        input logic pbit, input logic stop);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++) begin
            bit_out(c[i]);
        end
        if (pen) begin
            bit_out(pbit);
        end
        bit_out(stop);
        // one idle bit so a low stop bit is not read as a new start
        bit_out(1'b1);
    endtask
    task automatic brk(input int n);
        repeat (n) bit_out(1'b0);
        bit_out(1'b1);
    endtask
endmodule // serial_tx_model
`default_nettype wire

//--- testbench/tb_uart_rx_err_top.sv
// self-checking bench of the receive data and error status block
`timescale 1ns/1ps
`default_nettype none
`include "uart_rx_cfg.svh"
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
end
module tb_uart_rx_err_top;
    logic CLK_SYS, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic RXD, TX_VALID, ERR_IRQ, err;
    logic [7:0] TX_DATA;
    int n_fail = 0;
    int n_tests = 0;

    // small fifo so the overrun case stays short
    uart_rx_err_top #(.DEPTH(4), .AW(2)) i_uart_rx_err_top (
        .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .RXD(RXD), .TX_DATA(TX_DATA),
        .TX_VALID(TX_VALID), .ERR_IRQ(ERR_IRQ)
    );
    serial_tx_model i_serial_tx_model (.clk(CLK_SYS), .line(RXD));

    initial begin
        CLK_SYS = 1'b0;
        forever #10 CLK_SYS = ~CLK_SYS;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK_SYS);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_fail++;
            complete_run();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic chk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask

    // even parity selected, so a correct parity bit is the xor of the data
    task automatic good(input logic [7:0] c);
        i_serial_tx_model.send(c, 1'b1, ^c, 1'b1);
    endtask

    initial begin
        repeat (60000) @(posedge CLK_SYS);
        n_fail++;
        complete_run();
    end

    initial begin
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0000_0000;
        SYS_RST = 1'b1;
        repeat (16) @(posedge CLK_SYS);
        SYS_RST <= 1'b0;
        chk(`A_STAT, 32'h0000_0000, "stat_rst");
        chk(`A_DATA, 32'h0000_0000, "data_rst");
        `CHK("irq_rst", 1'b0, ERR_IRQ)
        wr(`A_BAUD, 32'h0000_0000);
        wr(`A_LCTL, 32'h0000_0016);
        wr(`A_IEN, 32'h0000_000F);
        // plain character both ways
        good(8'hA5);
        chk(`A_DATA, 32'h0000_00A5, "rx_char");
        wr(`A_DATA, 32'h0000_005A);
        #1;
        `CHK("tx_valid", 1'b1, TX_VALID)
        `CHK("tx_data", 8'h5A, TX_DATA)
        chk(`A_STAT, 32'h0000_0000, "stat_clean");
        // parity fault then stop fault, flags follow the head
        i_serial_tx_model.send(8'h11, 1'b1, ~^8'h11, 1'b1);
        i_serial_tx_model.send(8'h22, 1'b1, ^8'h22, 1'b0);
        `CHK("irq_err", 1'b1, ERR_IRQ)
        chk(`A_IRAW, 32'h0000_0003, "raw");
        chk(`A_IMSK, 32'h0000_0003, "masked");
        chk(`A_STAT, 32'h0000_0002, "stat_head1");
        chk(`A_DATA, 32'h0000_0211, "data_par");
        chk(`A_STAT, 32'h0000_0003, "stat_head2");
        chk(`A_DATA, 32'h0000_0122, "data_stop");
        wr(`A_STAT, 32'h0000_0000);
        chk(`A_STAT, 32'h0000_0000, "ecr_clear");
        wr(`A_ICLR, 32'h0000_000F);
        chk(`A_IRAW, 32'h0000_0000, "raw_clr");
        `CHK("irq_clr", 1'b0, ERR_IRQ)
        // long break gives one zero character, then reception resumes
        i_serial_tx_model.brk(30);
        good(8'h3C);
        chk(`A_DATA, 32'h0000_0400, "brk_char");
        chk(`A_DATA, 32'h0000_003C, "after_brk");
        chk(`A_DATA, 32'h0000_0000, "brk_empty");
        chk(`A_STAT, 32'h0000_0004, "stat_brk");
        wr(`A_STAT, 32'hFFFF_FFFF);
        wr(`A_ICLR, 32'h0000_000F);
        // overrun with the interrupt masked off
        wr(`A_IEN, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            good(8'h41 + 8'(i));
        end
        chk(`A_STAT, 32'h0000_0008, "stat_ovr");
        chk(`A_IRAW, 32'h0000_0008, "raw_ovr");
        chk(`A_IMSK, 32'h0000_0000, "msk_ovr");
        `CHK("irq_masked", 1'b0, ERR_IRQ)
        chk(`A_DATA, 32'h0000_0841, "ovr_head");
        for (int i = 1; i < 4; i++) begin
            chk(`A_DATA, 32'h0000_0041 + i, "drain");
        end
        chk(`A_DATA, 32'h0000_0000, "lost_fifth");
        wr(`A_STAT, 32'h0000_0000);
        wr(`A_ICLR, 32'h0000_000F);
        // unmapped and read-only places
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        `CHK("slverr", 1'b1, err)
        apb(1'b1, `A_IRAW, 32'h0000_000F);
        `CHK("ro_noerr", 1'b0, err)
        chk(`A_IRAW, 32'h0000_0000, "raw_ro");
        // fifo off: one holding place overruns on the second character
        wr(`A_LCTL, 32'h0000_0006);
        good(8'h61);
        good(8'h62);
        chk(`A_STAT, 32'h0000_0008, "hold_ovr");
        chk(`A_DATA, 32'h0000_0861, "hold_char");
        chk(`A_DATA, 32'h0000_0000, "hold_empty");
        // odd parity, stick parity, then no parity bit at all
        wr(`A_LCTL, 32'h0000_0012);
        i_serial_tx_model.send(8'h07, 1'b1, ~^8'h07, 1'b1);
        chk(`A_DATA, 32'h0000_0007, "odd_par");
        wr(`A_LCTL, 32'h0000_0092);
        i_serial_tx_model.send(8'h07, 1'b1, 1'b0, 1'b1);
        chk(`A_DATA, 32'h0000_0207, "stick_par");
        wr(`A_LCTL, 32'h0000_0010);
        i_serial_tx_model.send(8'hC3, 1'b0, 1'b0, 1'b1);
        chk(`A_DATA, 32'h0000_00C3, "no_par");
        complete_run();
    end
endmodule // tb_uart_rx_err_top
`default_nettype wire
